// ### design/clio_pkg.sv
// Constants and types shared by the camera line I/O controller.
package clio_pkg;

  // Register byte addresses on the Wishbone slave.
  localparam logic [7:0] ADDR_PICK = 8'h00;
  localparam logic [7:0] ADDR_LINE_CFG = 8'h04;
  localparam logic [7:0] ADDR_FILTER = 8'h08;
  localparam logic [7:0] ADDR_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_ALL_LEVELS = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [7:0] ADDR_FLASH_COUNT = 8'h18;
  localparam logic [7:0] ADDR_FLASH_HIGH = 8'h1C;
  localparam logic [7:0] ADDR_FLASH_LOW = 8'h20;

  // Field positions in the line configuration register.
  localparam int CFG_USAGE_LSB = 0;
  localparam int CFG_ORIGIN_LSB = 2;
  localparam int CFG_FLIP_BIT = 4;

  // Field positions in the control register.
  localparam int CTRL_FLASH_EN_BIT = 0;
  localparam int CTRL_MANUAL_BIT = 1;
  localparam int CTRL_AUX_BIT = 2;
  localparam int CTRL_WINDOW_LSB = 4;

  // Values after reset.
  localparam logic [15:0] RST_FILTER_US = 16'h0000;
  localparam logic [15:0] RST_FLASH_COUNT = 16'h0000;
  localparam logic [23:0] RST_FLASH_HIGH = 24'h00_0064;
  localparam logic [23:0] RST_FLASH_LOW = 24'h00_0064;

  // Clock rate and the microsecond tick derived from it.
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    USE_INPUT = 2'b00,
    USE_TRIGGER = 2'b01,
    USE_FLASH = 2'b10,
    USE_OUTPUT = 2'b11
  } clio_usage_t;

  typedef enum logic [1:0] {
    ORG_EXPOSURE = 2'b00,
    ORG_TRIGGER = 2'b01,
    ORG_MANUAL = 2'b10
  } clio_origin_t;

  typedef enum logic [1:0] {
    WIN_FIRST_ROW = 2'b00,
    WIN_ANY_PIXEL = 2'b01,
    WIN_ALL_PIXELS = 2'b10
  } clio_window_t;

endpackage : clio_pkg

// ### design/clio_flash_if.sv
// Interface between the controller and its flash pulse train generator.
`timescale 1ns/1ps
interface clio_flash_if;
  logic enable;
  logic window;
  logic [15:0] count;
  logic [23:0] high_cycles;
  logic [23:0] low_cycles;
  logic flash;

  modport ctrl (output enable, window, count, high_cycles, low_cycles, input flash);
  modport gen (input enable, window, count, high_cycles, low_cycles, output flash);
endinterface : clio_flash_if

// ### design/clio_filter.sv
// Two-flop synchroniser and stability filter for one connector line.
`timescale 1ns/1ps
module clio_filter
  import clio_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Line and timing.
  input wire logic pin_i,
  input wire logic us_tick_i,
  input wire logic [15:0] filter_us_i,
  // Filtered level.
  output logic level_o
);

  logic sync_a;
  logic sync_b;
  logic [15:0] stable_us;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
    end
  end

  // A new level passes only after it held for the whole interval.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stable_us <= 16'h0000;
      level_o <= 1'b0;
    end else if (sync_b == level_o) begin
      stable_us <= 16'h0000;
    end else if (stable_us >= filter_us_i) begin
      level_o <= sync_b;
      stable_us <= 16'h0000;
    end else if (us_tick_i) begin
      stable_us <= stable_us + 16'h0001;
    end
  end

endmodule : clio_filter

// ### design/clio_flash.sv
// Flash pulse train generator started by the exposure window.
`timescale 1ns/1ps
module clio_flash
  import clio_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Controller side.
  clio_flash_if.gen fl
);

  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_HIGH = 2'b01,
    FS_LOW = 2'b10
  } clio_flash_state_t;

  clio_flash_state_t state;
  logic window_d;
  logic [23:0] timer;
  logic [15:0] left;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      window_d <= 1'b0;
    end else begin
      window_d <= fl.window;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !fl.enable) begin
      state <= FS_IDLE;
      timer <= 24'h00_0000;
      left <= 16'h0000;
    end else begin
      case (state)
        FS_IDLE: begin
          if (fl.window && !window_d && fl.count != 16'h0000) begin
            state <= FS_HIGH;
            timer <= fl.high_cycles;
            left <= fl.count;
          end
        end
        FS_HIGH: begin
          if (timer <= 24'h00_0001) begin
            state <= FS_LOW;
            timer <= fl.low_cycles;
            left <= left - 16'h0001;
          end else begin
            timer <= timer - 24'h00_0001;
          end
        end
        FS_LOW: begin
          if (timer > 24'h00_0001) begin
            timer <= timer - 24'h00_0001;
          end else if (left != 16'h0000) begin
            state <= FS_HIGH;
            timer <= fl.high_cycles;
          end else begin
            state <= FS_IDLE;
          end
        end
        default: begin
          state <= FS_IDLE;
        end
      endcase
    end
  end

  // A zero count makes the flash follow the window as one level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fl.flash <= 1'b0;
    end else if (fl.count == 16'h0000) begin
      fl.flash <= fl.enable & fl.window;
    end else begin
      fl.flash <= (state == FS_HIGH);
    end
  end

endmodule : clio_flash

// ### design/clio_line_io.sv
// Camera connector line controller with a Wishbone register slave.
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// How it works
// - PICK register selects which of lines 0..3 per-line accesses address.
// - Picked line usage is input, trigger, flash or output, per-line allowed set.
// - Output origin selects exposure-active, trigger-active or the manual output level as the pin source.
// - Output origin drives the pin only in output usage.
// - Polarity flip inverts the picked line as input or output.
// - Manual output level drives the user output high or low.
// - Per-line filter interval in microseconds applies to input lines.
// - LEVEL read returns the picked line's present level.
// - ALL_LEVELS read returns every line's level in one word.
// - Flash emits a counted pulse train with programmable high and low times.
// - Any-pixel flash window exists only under global reset, all-pixels window only without it.
// - Window code 00 first row, 01 any pixel, 10 all pixels.
// - Control bit switches the auxiliary supply output.
// - Flash enable low stops all flash pulses.
module clio_line_io
  import clio_pkg::*;
#(
  parameter int NUM_LINES = 4,
  parameter logic [15:0] USAGE_ALLOWED = 16'hFFFF
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Connector lines.
  input wire logic [NUM_LINES-1:0] line_in_i,
  output logic [NUM_LINES-1:0] line_out_o,
  output logic [NUM_LINES-1:0] line_oe_o,
  // Camera signals.
  input wire logic exposure_active_i,
  input wire logic trigger_active_i,
  input wire logic first_row_exposing_i,
  input wire logic last_row_exposing_i,
  input wire logic global_reset_mode_i,
  // Results.
  output logic trigger_o,
  output logic user_output_o,
  output logic aux_supply_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [1:0] pin_pick;
  clio_usage_t pin_usage [NUM_LINES];
  clio_origin_t pin_output_origin [NUM_LINES];
  logic [NUM_LINES-1:0] pin_polarity_flip;
  logic [15:0] pin_glitch_filter_time [NUM_LINES];
  logic flash_signal_enable;
  logic manual_output_level;
  logic aux_supply_enable;
  clio_window_t exposure_window_select;
  logic [15:0] flash_count;
  logic [23:0] flash_high;
  logic [23:0] flash_low;

  logic [NUM_LINES-1:0] filtered;
  logic [NUM_LINES-1:0] line_level;
  logic [NUM_LINES-1:0] next_out;
  logic [NUM_LINES-1:0] next_oe;
  logic [6:0] us_div;
  logic us_tick;
  logic bus_req;
  logic bus_wr;
  logic [31:0] wmask;
  logic [31:0] cfg_word;
  logic [31:0] cfg_new;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_new;
  logic [31:0] rd_word;
  logic [3:0] allowed_bits;
  logic window;

  clio_flash_if flif ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one answer per request, one cycle after it.

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
    end
  end

  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[CFG_USAGE_LSB +: 2] = pin_usage[pin_pick];
    cfg_word[CFG_ORIGIN_LSB +: 2] = pin_output_origin[pin_pick];
    cfg_word[CFG_FLIP_BIT] = pin_polarity_flip[pin_pick];
    cfg_new = (cfg_word & ~wmask) | (wb_dat_i & wmask);
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_FLASH_EN_BIT] = flash_signal_enable;
    ctrl_word[CTRL_MANUAL_BIT] = manual_output_level;
    ctrl_word[CTRL_AUX_BIT] = aux_supply_enable;
    ctrl_word[CTRL_WINDOW_LSB +: 2] = exposure_window_select;
    ctrl_new = (ctrl_word & ~wmask) | (wb_dat_i & wmask);
  end

  assign allowed_bits = USAGE_ALLOWED[pin_pick*4 +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_pick <= 2'b00;
    end else if (bus_wr && wb_adr_i == ADDR_PICK && wb_sel_i[0]) begin
      pin_pick <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        pin_usage[i] <= USE_INPUT;
        pin_output_origin[i] <= ORG_EXPOSURE;
        pin_glitch_filter_time[i] <= RST_FILTER_US;
      end
      pin_polarity_flip <= '0;
    end else if (bus_wr && wb_adr_i == ADDR_LINE_CFG) begin
      // Usages that this line does not offer are ignored.
      if (allowed_bits[cfg_new[CFG_USAGE_LSB +: 2]]) begin
        pin_usage[pin_pick] <= clio_usage_t'(cfg_new[CFG_USAGE_LSB +: 2]);
      end
      if (cfg_new[CFG_ORIGIN_LSB +: 2] != 2'b11) begin
        pin_output_origin[pin_pick] <= clio_origin_t'(cfg_new[CFG_ORIGIN_LSB +: 2]);
      end
      pin_polarity_flip[pin_pick] <= cfg_new[CFG_FLIP_BIT];
    end else if (bus_wr && wb_adr_i == ADDR_FILTER) begin
      pin_glitch_filter_time[pin_pick] <= (pin_glitch_filter_time[pin_pick] & ~wmask[15:0])
        | (wb_dat_i[15:0] & wmask[15:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_signal_enable <= 1'b0;
      manual_output_level <= 1'b0;
      aux_supply_enable <= 1'b0;
      exposure_window_select <= WIN_FIRST_ROW;
    end else if (bus_wr && wb_adr_i == ADDR_CTRL) begin
      flash_signal_enable <= ctrl_new[CTRL_FLASH_EN_BIT];
      manual_output_level <= ctrl_new[CTRL_MANUAL_BIT];
      aux_supply_enable <= ctrl_new[CTRL_AUX_BIT];
      exposure_window_select <= clio_window_t'(ctrl_new[CTRL_WINDOW_LSB +: 2]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_count <= RST_FLASH_COUNT;
      flash_high <= RST_FLASH_HIGH;
      flash_low <= RST_FLASH_LOW;
    end else if (bus_wr) begin
      if (wb_adr_i == ADDR_FLASH_COUNT) begin
        flash_count <= (flash_count & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      if (wb_adr_i == ADDR_FLASH_HIGH) begin
        flash_high <= (flash_high & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
      end
      if (wb_adr_i == ADDR_FLASH_LOW) begin
        flash_low <= (flash_low & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; unmapped addresses answer zero.

  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      ADDR_PICK: rd_word[1:0] = pin_pick;
      ADDR_LINE_CFG: rd_word = cfg_word;
      ADDR_FILTER: rd_word[15:0] = pin_glitch_filter_time[pin_pick];
      ADDR_LEVEL: rd_word[0] = line_level[pin_pick];
      ADDR_ALL_LEVELS: rd_word[NUM_LINES-1:0] = line_level;
      ADDR_CTRL: rd_word = ctrl_word;
      ADDR_FLASH_COUNT: rd_word[15:0] = flash_count;
      ADDR_FLASH_HIGH: rd_word[23:0] = flash_high;
      ADDR_FLASH_LOW: rd_word[23:0] = flash_low;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Microsecond tick for the line filters.

  always_ff @(posedge clk_i) begin
    if (rst_i || us_tick) begin
      us_div <= 7'h00;
    end else begin
      us_div <= us_div + 7'h01;
    end
  end

  assign us_tick = (us_div == 7'(CYC_PER_US - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Exposure window that starts the flash.

  always_comb begin
    case (exposure_window_select)
      WIN_ANY_PIXEL: begin
        if (global_reset_mode_i) begin
          window = first_row_exposing_i | last_row_exposing_i;
        end else begin
          window = first_row_exposing_i;
        end
      end
      WIN_ALL_PIXELS: begin
        if (global_reset_mode_i) begin
          window = first_row_exposing_i;
        end else begin
          window = first_row_exposing_i & last_row_exposing_i;
        end
      end
      default: window = first_row_exposing_i;
    endcase
  end

  assign flif.enable = flash_signal_enable;
  assign flif.window = window;
  assign flif.count = flash_count;
  assign flif.high_cycles = flash_high;
  assign flif.low_cycles = flash_low;

  clio_flash u_flash (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fl(flif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-line filter, level and pin drive.

  for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
    clio_filter u_filter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(line_in_i[g]),
      .us_tick_i(us_tick),
      .filter_us_i(pin_glitch_filter_time[g]),
      .level_o(filtered[g])
    );

    assign line_level[g] = filtered[g] ^ pin_polarity_flip[g];

    always_comb begin
      next_out[g] = 1'b0;
      next_oe[g] = 1'b0;
      case (pin_usage[g])
        USE_FLASH: begin
          next_oe[g] = 1'b1;
          next_out[g] = flif.flash;
        end
        USE_OUTPUT: begin
          next_oe[g] = 1'b1;
          case (pin_output_origin[g])
            ORG_TRIGGER: next_out[g] = trigger_active_i;
            ORG_MANUAL: next_out[g] = manual_output_level;
            default: next_out[g] = exposure_active_i;
          endcase
        end
        default: next_oe[g] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_out_o <= '0;
      line_oe_o <= '0;
      trigger_o <= 1'b0;
      user_output_o <= 1'b0;
      aux_supply_en_o <= 1'b0;
    end else begin
      line_out_o <= next_out ^ pin_polarity_flip;
      line_oe_o <= next_oe;
      trigger_o <= 1'b0;
      for (int i = 0; i < NUM_LINES; i++) begin
        if (pin_usage[i] == USE_TRIGGER && line_level[i]) begin
          trigger_o <= 1'b1;
        end
      end
      user_output_o <= manual_output_level;
      aux_supply_en_o <= aux_supply_enable;
    end
  end

endmodule : clio_line_io

// ### verif/clio_line_io_sva.sv
// Assertion checker for the camera line controller ports.
`timescale 1ns/1ps
module clio_line_io_sva
  import clio_pkg::*;
#(
  parameter int NUM_LINES = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Outputs.
  input wire logic [NUM_LINES-1:0] line_oe_o,
  input wire logic user_output_o,
  input wire logic aux_supply_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  sequence s_ctrl_wr;
    req && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0];
  endsequence

  sequence s_rd(logic [7:0] a);
    req && !wb_we_i && wb_adr_i == a ##1 wb_ack_o;
  endsequence

  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stayed high");
  a_ack_after_req: assert property (req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_reset_quiet: assert property ($past(rst_i) |->
    line_oe_o == '0 && !user_output_o && !aux_supply_en_o)
    else $error("outputs active after reset");
  a_manual_tracks: assert property (s_ctrl_wr |->
    ##2 user_output_o == $past(wb_dat_i[CTRL_MANUAL_BIT], 2))
    else $error("user output does not follow manual level");
  a_aux_tracks: assert property (s_ctrl_wr |->
    ##2 aux_supply_en_o == $past(wb_dat_i[CTRL_AUX_BIT], 2))
    else $error("aux supply does not follow control bit");
  a_level_width: assert property (s_rd(ADDR_LEVEL) |-> wb_dat_o[31:1] == '0)
    else $error("level read has upper bits set");
  a_all_width: assert property (s_rd(ADDR_ALL_LEVELS) |-> wb_dat_o[31:NUM_LINES] == '0)
    else $error("all levels read has upper bits set");
  a_unmapped_zero: assert property (s_rd(8'h24) |-> wb_dat_o == '0)
    else $error("unmapped read not zero");
endmodule : clio_line_io_sva

bind clio_line_io clio_line_io_sva #(.NUM_LINES(NUM_LINES)) i_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_oe_o(line_oe_o),
  .user_output_o(user_output_o), .aux_supply_en_o(aux_supply_en_o));

// ### verif/clio_ext_dev.sv
// Model of the devices wired to the connector lines.
`timescale 1ns/1ps
module clio_ext_dev (
  // Design side.
  input wire logic [3:0] line_out_i,
  input wire logic [3:0] line_oe_i,
  // Bench control.
  input wire logic [3:0] drive_en_i,
  input wire logic [3:0] drive_val_i,
  // Wire levels.
  output logic [3:0] pin_o
);
  // A line nobody drives floats to its pull-up level.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pin_o[k] = line_oe_i[k] ? line_out_i[k] : (drive_en_i[k] ? drive_val_i[k] : 1'b1);
    end
  end
endmodule : clio_ext_dev

// ### verif/clio_line_io_tb_top.sv
// Self-checking bench for the camera line controller.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module clio_line_io_tb_top
  import clio_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, trig, uo, aux;
  logic exp_a = 0, trg_a = 0, first = 0, last = 0, gmode = 0, prev_fl = 0, hit;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0, drv_en = '0, drv_val = '0, pin, l_out, l_oe, flips = '0;
  logic [31:0] dat = '0, rdat, rd;
  int n_mismatch = 0, n_checks = 0, cyc_cnt = 0, seed = 61859, pulses, hcyc;
  int m_cfg[4];
  int exp_q[$];

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  clio_line_io i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .line_in_i(pin), .line_out_o(l_out), .line_oe_o(l_oe),
    .exposure_active_i(exp_a), .trigger_active_i(trg_a), .first_row_exposing_i(first),
    .last_row_exposing_i(last), .global_reset_mode_i(gmode), .trigger_o(trig),
    .user_output_o(uo), .aux_supply_en_o(aux));

  clio_ext_dev i_ext (.line_out_i(l_out), .line_oe_i(l_oe), .drive_en_i(drv_en),
    .drive_val_i(drv_val), .pin_o(pin));

  always @(posedge clk_i) begin
    pulses += int'(l_out[0] && !prev_fl);
    hcyc += int'(l_out[0]);
    prev_fl = l_out[0];
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 0;
    stb <= 0;
  endtask : wb

  task automatic setcfg(input int k, input clio_usage_t u, input clio_origin_t o,
                        input logic f);
    m_cfg[k] = int'({f, o, u});
    flips[k] = f;
    wb(ADDR_PICK, 1, 32'(k), 4'hf);
    wb(ADDR_LINE_CFG, 1, 32'(m_cfg[k]), 4'hf);
  endtask : setcfg

  task automatic flash(input logic en, input int code, input logic fst, input logic lst);
    wb(ADDR_CTRL, 1, 32'((code << CTRL_WINDOW_LSB) | int'(en)), 4'h1);
    pulses = 0;
    hcyc = 0;
    first <= fst;
    last <= lst;
    repeat (80) @(posedge clk_i);
    first <= 0;
    last <= 0;
    repeat (20) @(posedge clk_i);
  endtask : flash

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    wb(ADDR_FLASH_HIGH, 0, 0, 4'hf);
    `CHK("flash_high", 32'h0000_0064, rd);
    wb(8'h24, 1, 32'hffff_ffff, 4'hf);
    wb(8'h24, 0, 0, 4'hf);
    `CHK("unmapped", 32'h0000_0000, rd);
    wb(ADDR_CTRL, 1, 32'h0000_0004, 4'h0);
    repeat (2) @(posedge clk_i);
    `CHK("aux_nosel", 1'b0, aux);
    for (int k = 0; k < 4; k++) setcfg(k, USE_OUTPUT, ORG_MANUAL, 1'($random(seed)));
    for (int m = 0; m < 2; m++) begin
      wb(ADDR_CTRL, 1, 32'(m * 2 + 4), 4'h1);
      repeat (8) @(posedge clk_i);
      `CHK("manual", 1'(m), uo);
      `CHK("aux_on", 1'b1, aux);
      `CHK("out_pins", {4{1'(m)}} ^ flips, l_out);
      wb(ADDR_ALL_LEVELS, 0, 0, 4'hf);
      `CHK("all_out", 32'({4{1'(m)}}), rd);
    end
    for (int k = 0; k < 4; k++) begin
      setcfg(k, USE_OUTPUT, ORG_EXPOSURE, flips[k]);
      exp_a <= 1'($random(seed));
      trg_a <= 1'($random(seed));
      repeat (3) @(posedge clk_i);
      `CHK("exp_src", exp_a ^ flips[k], l_out[k]);
      setcfg(k, USE_OUTPUT, ORG_TRIGGER, flips[k]);
      repeat (3) @(posedge clk_i);
      `CHK("trg_src", trg_a ^ flips[k], l_out[k]);
      setcfg(k, USE_INPUT, ORG_TRIGGER, flips[k]);
      repeat (3) @(posedge clk_i);
      `CHK("in_oe", 1'b0, l_oe[k]);
    end
    drv_en <= 4'hf;
    drv_val <= 4'($random(seed));
    repeat (10) @(posedge clk_i);
    wb(ADDR_ALL_LEVELS, 0, 0, 4'hf);
    `CHK("all_in", 32'(drv_val ^ flips), rd);
    for (int k = 0; k < 4; k++) begin
      wb(ADDR_PICK, 1, 32'(k), 4'hf);
      wb(ADDR_LINE_CFG, 0, 0, 4'hf);
      `CHK("cfg", 32'(m_cfg[k]), rd);
      wb(ADDR_LEVEL, 0, 0, 4'hf);
      `CHK("level", 32'(drv_val[k] ^ flips[k]), rd);
    end
    setcfg(2, USE_TRIGGER, ORG_EXPOSURE, 1'b0);
    wb(ADDR_FILTER, 1, 32'h0000_0002, 4'hf);
    drv_val[2] <= 0;
    repeat (400) @(posedge clk_i);
    drv_val[2] <= 1;
    repeat (60) @(posedge clk_i);
    drv_val[2] <= 0;
    hit = 0;
    repeat (300) begin
      @(posedge clk_i);
      hit |= trig;
    end
    `CHK("glitch", 1'b0, hit);
    drv_val[2] <= 1;
    repeat (400) @(posedge clk_i);
    `CHK("trig", 1'b1, trig);
    wb(ADDR_PICK, 1, 32'h0000_0003, 4'hf);
    wb(ADDR_FILTER, 0, 0, 4'hf);
    `CHK("filter_own", 32'h0000_0000, rd);
    setcfg(0, USE_FLASH, ORG_EXPOSURE, 1'b0);
    wb(ADDR_FLASH_COUNT, 1, 32'h0000_0003, 4'hf);
    wb(ADDR_FLASH_HIGH, 1, 32'h0000_0004, 4'hf);
    wb(ADDR_FLASH_LOW, 1, 32'h0000_0006, 4'hf);
    gmode <= 1;
    for (int c = 0; c < 6; c++) begin
      exp_q.push_back((c % 2 == 1 || c / 2 == 1) ? 3 : 0);
      flash(1'b1, c / 2, 1'(c % 2), 1'b1);
      `CHK("pulses", exp_q.pop_front(), pulses);
      `CHK("high_time", pulses * 4, hcyc);
    end
    flash(1'b0, 1, 1'b1, 1'b1);
    `CHK("disabled", 0, pulses);
    // Without a global reset the any-pixel code falls back to the first row window; all pixels needs both rows.
    gmode <= 0;
    flash(1'b1, 1, 1'b0, 1'b1);
    `CHK("any_no_grst", 0, pulses);
    flash(1'b1, 2, 1'b1, 1'b0);
    `CHK("all_no_grst", 0, pulses);
    flash(1'b1, 3, 1'b1, 1'b0);
    `CHK("code3_first", 3, pulses);
    // A zero count makes the flash follow the 80 cycle window as one level.
    wb(ADDR_FLASH_COUNT, 1, 32'h0000_0000, 4'hf);
    flash(1'b1, 0, 1'b1, 1'b0);
    `CHK("level_pulses", 1, pulses);
    `CHK("level_high", 80, hcyc);
    end_sim();
  end
endmodule : clio_line_io_tb_top
